// file: spf_strap_and_pin_function_select.sv
// Purpose: Shared pin routing, pullup control and strap sampling.
// Assumes: All inputs synchronous to clk_sys; reset is the global reset.
// Notes: Open-drain serial lines drive low only; pullups are outputs here.
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module spf_strap_and_pin_function_select (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic pcie_reset_n_in,
  input wire logic [spf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [spf_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [spf_pkg::DATA_W-1:0] reg_rdata,
  input wire logic general_pin_three_in,
  output logic general_pin_three_out,
  output logic general_pin_three_oe,
  output logic general_pin_three_pull_en,
  input wire logic general_pin_four_in,
  output logic general_pin_four_out,
  output logic general_pin_four_oe,
  output logic general_pin_four_pull_en,
  input wire logic sb_data_drive_low,
  input wire logic sb_clock_drive_low,
  output logic sb_data_in,
  output logic sb_clock_in,
  output logic sb_mode,
  input wire logic pci_clock_freq_strap,
  input wire logic m66en_in,
  output logic pci_clock_freq_66,
  output logic [6:0] pci_clock_outputs_mhz,
  input wire logic serial_interrupt_line_in,
  output logic serial_interrupt_enable
);

  logic [spf_pkg::CTRL_W-1:0] ctrl_q;
  logic [spf_pkg::STRAP_W-1:0] strap_in;
  logic [spf_pkg::STRAP_W-1:0] strap_q;
  logic [spf_pkg::ST_W-1:0] status;
  logic first_q;
  logic perst_prev_q;
  logic capture;
  logic sb_data_q;
  logic sb_clock_q;
  logic gpio_out3_q;
  logic gpio_out4_q;
  logic dir3;
  logic dir4;

  // ----------------------------------------------------------------
  // Strap sampling
  // ----------------------------------------------------------------
  // Capture in the first cycle after global reset and at each PERST release.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      first_q <= 1'b1;
      perst_prev_q <= 1'b0;
    end else begin
      first_q <= 1'b0;
      perst_prev_q <= pcie_reset_n_in;
    end
  end

  // Gated by reset so the release edge, where the latch is still held, is no capture.
  assign capture = !reset && (first_q || (pcie_reset_n_in && !perst_prev_q));

  always_comb begin
    strap_in = '0;
    strap_in[spf_pkg::STRAP_SCL_BIT] = general_pin_four_in;
    strap_in[spf_pkg::STRAP_CLK_BIT] = pci_clock_freq_strap;
    strap_in[spf_pkg::STRAP_SERIAL_INTERRUPT_LINE_BIT] = serial_interrupt_line_in;
  end

  spf_strap_latch #(
    .WIDTH(spf_pkg::STRAP_W)
  ) u_latch (
    .clk_sys(clk_sys),
    .reset(reset),
    .capture(capture),
    .strap_in(strap_in),
    .strap_q(strap_q)
  );

  // A pulldown reads low and leaves the interface off.
  assign serial_interrupt_enable = strap_q[spf_pkg::STRAP_SERIAL_INTERRUPT_LINE_BIT];

  // ----------------------------------------------------------------
  // PCI clock frequency
  // ----------------------------------------------------------------
  // The 66 MHz default needs both the strap and M66EN high.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pci_clock_freq_66 <= 1'b0;
      pci_clock_outputs_mhz <= spf_pkg::FREQ_LOW_MHZ;
    end else begin
      pci_clock_freq_66 <= strap_q[spf_pkg::STRAP_CLK_BIT] && m66en_in;
      pci_clock_outputs_mhz <= (strap_q[spf_pkg::STRAP_CLK_BIT] && m66en_in) ?
        spf_pkg::FREQ_HIGH_MHZ : spf_pkg::FREQ_LOW_MHZ;
    end
  end

  // ----------------------------------------------------------------
  // Pin function select
  // ----------------------------------------------------------------
  assign sb_mode = strap_q[spf_pkg::STRAP_SCL_BIT] || ctrl_q[spf_pkg::CTRL_FORCE_BIT];
  assign dir3 = ctrl_q[spf_pkg::CTRL_DIR3_BIT];
  assign dir4 = ctrl_q[spf_pkg::CTRL_DIR4_BIT];

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      gpio_out3_q <= 1'b0;
      gpio_out4_q <= 1'b0;
    end else begin
      gpio_out3_q <= sb_mode ? 1'b0 : ctrl_q[spf_pkg::CTRL_OUT3_BIT];
      gpio_out4_q <= sb_mode ? 1'b0 : ctrl_q[spf_pkg::CTRL_OUT4_BIT];
    end
  end

  // Serial lines are open drain: enable only while pulling low; board pullups lift them.
  assign general_pin_three_out = gpio_out3_q;
  assign general_pin_four_out = gpio_out4_q;
  assign general_pin_three_oe = sb_mode ? sb_data_drive_low : dir3;
  assign general_pin_four_oe = sb_mode ? sb_clock_drive_low : dir4;

  // The pullup is on during reset or while the pin acts as a general input.
  assign general_pin_three_pull_en = reset || (!sb_mode && !dir3);
  assign general_pin_four_pull_en = reset || (!sb_mode && !dir4);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sb_data_q <= 1'b1;
      sb_clock_q <= 1'b1;
    end else begin
      sb_data_q <= sb_mode ? general_pin_three_in : 1'b1;
      sb_clock_q <= sb_mode ? general_pin_four_in : 1'b1;
    end
  end

  assign sb_data_in = sb_data_q;
  assign sb_clock_in = sb_clock_q;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_q <= spf_pkg::CTRL_RESET;
    end else if (reg_write && reg_addr == spf_pkg::CTRL_OFS) begin
      ctrl_q <= reg_wdata[spf_pkg::CTRL_W-1:0];
    end
  end

  always_comb begin
    status = '0;
    status[spf_pkg::ST_SCL_PULL_BIT] = strap_q[spf_pkg::STRAP_SCL_BIT];
    status[spf_pkg::ST_SB_MODE_BIT] = sb_mode;
    status[spf_pkg::ST_CLK_STRAP_BIT] = strap_q[spf_pkg::STRAP_CLK_BIT];
    status[spf_pkg::ST_FREQ66_BIT] = pci_clock_freq_66;
    status[spf_pkg::ST_SERIAL_INTERRUPT_LINE_BIT] = serial_interrupt_enable;
    status[spf_pkg::ST_PIN3_BIT] = general_pin_three_in;
    status[spf_pkg::ST_PIN4_BIT] = general_pin_four_in;
  end

  // Read data stand for one cycle only; unmapped offsets read as zero.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_read && reg_addr == spf_pkg::CTRL_OFS) begin
      reg_rdata <= {{(spf_pkg::DATA_W-spf_pkg::CTRL_W){1'b0}}, ctrl_q};
    end else if (reg_read && reg_addr == spf_pkg::STATUS_OFS) begin
      reg_rdata <= {{(spf_pkg::DATA_W-spf_pkg::ST_W){1'b0}}, status};
    end else begin
      reg_rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sb_route_a: assert property (@(posedge clk_sys) disable iff (reset)
    sb_mode |-> general_pin_four_oe == sb_clock_drive_low && general_pin_three_oe == sb_data_drive_low)
    else $error("serial-bus mode does not route the shared pins");
  force_mode_a: assert property (@(posedge clk_sys) disable iff (reset)
    ctrl_q[spf_pkg::CTRL_FORCE_BIT] |-> sb_mode)
    else $error("force bit did not select serial-bus mode");
  gpio_keep_a: assert property (@(posedge clk_sys) disable iff (reset)
    !sb_mode |=> !sb_mode || $past(capture) || $past(reg_write))
    else $error("mode changed without capture or write");
  gpio_dir_a: assert property (@(posedge clk_sys) disable iff (reset)
    !sb_mode |-> general_pin_three_oe == dir3 && general_pin_four_oe == dir4)
    else $error("general pin direction not honoured");
  sb_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
    !sb_mode |=> sb_data_in && sb_clock_in)
    else $error("serial-bus inputs not idle in general-purpose mode");
  pullup_only_a: assert property (@(posedge clk_sys) disable iff (reset)
    general_pin_three_pull_en |-> !general_pin_three_oe && !sb_mode)
    else $error("pullup on while pin three is not an input");
  pullup_four_a: assert property (@(posedge clk_sys) disable iff (reset)
    general_pin_four_pull_en |-> !general_pin_four_oe && !sb_mode)
    else $error("pullup on while pin four is not an input");
  reset_clear_a: assert property (@(posedge clk_sys)
    reset |-> ctrl_q == spf_pkg::CTRL_RESET && strap_q == spf_pkg::STRAP_RESET && general_pin_four_pull_en)
    else $error("state not cleared under reset");
  freq_select_a: assert property (@(posedge clk_sys) disable iff (reset)
    ##1 pci_clock_freq_66 == $past(strap_q[spf_pkg::STRAP_CLK_BIT] && m66en_in))
    else $error("PCI clock frequency select wrong");
  serial_interrupt_line_on_a: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(pcie_reset_n_in) && serial_interrupt_line_in |=> serial_interrupt_enable)
    else $error("serial interrupt not enabled after pullup strap");
  serial_interrupt_line_off_a: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(pcie_reset_n_in) && !serial_interrupt_line_in |=> !serial_interrupt_enable [*2])
    else $error("serial interrupt enabled despite pulldown strap");
  read_status_a: assert property (@(posedge clk_sys) disable iff (reset)
    reg_read && reg_addr == spf_pkg::STATUS_OFS |=> reg_rdata[spf_pkg::ST_W-1:0] == $past(status))
    else $error("status read returned wrong data");

  // Main scenarios: serial-bus entry, strap captures and a driven general pin.
  sb_entry_c: cover property (@(posedge clk_sys) disable iff (reset) $rose(sb_mode));
  serial_interrupt_line_en_c: cover property (@(posedge clk_sys) disable iff (reset) $rose(serial_interrupt_enable));
  freq66_c: cover property (@(posedge clk_sys) disable iff (reset) $rose(pci_clock_freq_66));
  gpio_out_c: cover property (@(posedge clk_sys) disable iff (reset) !sb_mode && general_pin_three_oe);

endmodule

// file: spf_pkg.sv
// Purpose: Shared constants for the strap and pin function select block.
// Assumes: One 125 MHz clock, asynchronous active-high global reset.
// Notes: Register offsets are byte addresses on the plain register port.
//
// What this block does
// - Pins three/four become serial data/clock on SCL pullup or force bit.
// - Otherwise both shared pins stay ordinary general-purpose inputs/outputs.
// - Pin pullup is on only during reset or while the pin is an input.
// - Global reset asynchronously resets every flip-flop; first_q, sb_data_q, sb_clock_q and the MHz code reset nonzero.
// - Clock strap low selects 50 MHz, high selects 66 MHz default clock.
// - The M66EN input also bears on the chosen PCI output clock frequency.
// - Serial interrupt enabled if its pin shows pullup at PERST release.
// - Serial interrupt stays disabled if its pin shows pulldown at release.
package spf_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;

  // Control register fields.
  localparam int CTRL_FORCE_BIT = 0;
  localparam int CTRL_DIR3_BIT = 1;
  localparam int CTRL_DIR4_BIT = 2;
  localparam int CTRL_OUT3_BIT = 3;
  localparam int CTRL_OUT4_BIT = 4;
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // Status register fields.
  localparam int ST_SCL_PULL_BIT = 0;
  localparam int ST_SB_MODE_BIT = 1;
  localparam int ST_CLK_STRAP_BIT = 2;
  localparam int ST_FREQ66_BIT = 3;
  localparam int ST_SERIAL_INTERRUPT_LINE_BIT = 4;
  localparam int ST_PIN3_BIT = 5;
  localparam int ST_PIN4_BIT = 6;
  localparam int ST_W = 7;

  // ----------------------------------------------------------------
  // Strap vector layout
  // ----------------------------------------------------------------
  localparam int STRAP_SCL_BIT = 0;
  localparam int STRAP_CLK_BIT = 1;
  localparam int STRAP_SERIAL_INTERRUPT_LINE_BIT = 2;
  localparam int STRAP_W = 3;
  localparam logic [2:0] STRAP_RESET = 3'h0;

  // Clock frequency codes in MHz, as the clock generator expects them.
  localparam logic [6:0] FREQ_LOW_MHZ = 7'h32;
  localparam logic [6:0] FREQ_HIGH_MHZ = 7'h42;

endpackage

// file: spf_strap_latch.sv
// Purpose: Holds sampled strap levels between capture strobes.
// Assumes: Strap inputs are synchronous to clk_sys.
// Notes: Values change only on the cycle after a capture strobe, or when reset clears them.
`timescale 1ns/1ps
module spf_strap_latch #(
  parameter int WIDTH = spf_pkg::STRAP_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic capture,
  input wire logic [WIDTH-1:0] strap_in,
  output logic [WIDTH-1:0] strap_q
);

  // ----------------------------------------------------------------
  // One capture flip-flop per strap
  // ----------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        strap_q[i] <= 1'b0;
      end else if (capture) begin
        strap_q[i] <= strap_in[i];
      end
    end
  end

  hold_stable_a: assert property (@(posedge clk_sys) disable iff (reset) !capture |=> $stable(strap_q))
    else $error("strap latch changed without a capture");
  take_value_a: assert property (@(posedge clk_sys) disable iff (reset) capture |=> strap_q == $past(strap_in))
    else $error("strap latch missed the sampled value");

endmodule

// file: spf_board_model.sv
// Purpose: Board-side straps, pull resistors and shared pin levels.
// Assumes: Pull codes are 2 for pullup, 1 for pulldown, 0 for none.
// Notes: A pin with neither a drive nor a pull toggles every cycle.
`timescale 1ns/1ps
module spf_board_model (
  input wire logic clk_sys,
  input wire logic [1:0] pin_three_pull,
  input wire logic [1:0] pin_four_pull,
  input wire logic serial_interrupt_line_pullup,
  input wire logic pin_three_oe,
  input wire logic pin_three_out,
  input wire logic pin_three_pull_en,
  input wire logic pin_four_oe,
  input wire logic pin_four_out,
  input wire logic pin_four_pull_en,
  output logic pin_three_level,
  output logic pin_four_level,
  output logic serial_interrupt_line_level
);
  logic float_q = 1'b0;
  always @(posedge clk_sys) float_q <= ~float_q;
  // A driven pin wins, a board resistor beats the weak internal pullup.
  function automatic logic pin_level(logic oe, logic dout, logic [1:0] pull, logic int_pu, logic flt);
    if (oe) return dout;
    if (pull == 2'h2) return 1'b1;
    if (pull == 2'h1) return 1'b0;
    return int_pu ? 1'b1 : flt;
  endfunction
  assign pin_three_level = pin_level(pin_three_oe, pin_three_out, pin_three_pull, pin_three_pull_en, float_q);
  assign pin_four_level = pin_level(pin_four_oe, pin_four_out, pin_four_pull, pin_four_pull_en, ~float_q);
  assign serial_interrupt_line_level = serial_interrupt_line_pullup;
endmodule

// file: spf_strap_and_pin_function_select_tb.sv
// Purpose: Self-checking bench for shared pin routing and strap capture.
// Assumes: Fixed latencies of the register port and strap capture.
// Notes: Straps are recaptured through the PERST input as well.
`timescale 1ns/1ps
module spf_strap_and_pin_function_select_tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b0;
  logic pcie_reset_n_in = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd;
  logic reg_write = 1'b0, reg_read = 1'b0, sb_data_drive_low = 1'b0, sb_clock_drive_low = 1'b0;
  logic pci_clock_freq_strap = 1'b1, m66en_in = 1'b1, serial_interrupt_line_pullup = 1'b1;
  logic [1:0] pull3 = 2'h2, pull4 = 2'h2;
  logic p3_in, p3_out, p3_oe, p3_pu, p4_in, p4_out, p4_oe, p4_pu, sb_data_in, sb_clock_in, sb_mode, f66, sirq_in, sirq_en;
  logic [6:0] mhz;
  int miscompares = 0;
  int samples_checked = 0;
  always #4 clk_sys = ~clk_sys;
  spf_strap_and_pin_function_select i_spf_strap_and_pin_function_select (.clk_sys(clk_sys), .reset(reset),
    .pcie_reset_n_in(pcie_reset_n_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .general_pin_three_in(p3_in), .general_pin_three_out(p3_out),
    .general_pin_three_oe(p3_oe), .general_pin_three_pull_en(p3_pu), .general_pin_four_in(p4_in),
    .general_pin_four_out(p4_out), .general_pin_four_oe(p4_oe), .general_pin_four_pull_en(p4_pu),
    .sb_data_drive_low(sb_data_drive_low), .sb_clock_drive_low(sb_clock_drive_low), .sb_data_in(sb_data_in),
    .sb_clock_in(sb_clock_in), .sb_mode(sb_mode), .pci_clock_freq_strap(pci_clock_freq_strap), .m66en_in(m66en_in),
    .pci_clock_freq_66(f66), .pci_clock_outputs_mhz(mhz), .serial_interrupt_line_in(sirq_in),
    .serial_interrupt_enable(sirq_en));
  spf_board_model i_spf_board_model (.clk_sys(clk_sys), .pin_three_pull(pull3), .pin_four_pull(pull4),
    .serial_interrupt_line_pullup(serial_interrupt_line_pullup), .pin_three_oe(p3_oe), .pin_three_out(p3_out), .pin_three_pull_en(p3_pu),
    .pin_four_oe(p4_oe), .pin_four_out(p4_out), .pin_four_pull_en(p4_pu), .pin_three_level(p3_in),
    .pin_four_level(p4_in), .serial_interrupt_line_level(sirq_in));
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic reg_wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
    #1 check("rdata_idle", reg_rdata, 32'h0);
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (9) @(posedge clk_sys);
    #1 check("pull_en", {p3_pu, p4_pu, p3_oe, p4_oe}, 32'hc);
    check("rst_clk", {f66, mhz, sirq_en}, {24'h0, spf_pkg::FREQ_LOW_MHZ, 1'b0});
    @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic end_of_test();
    $display("Counts: %0d checked, %0d miscompares", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end
  initial begin
    do_reset();
    check("sb_on", {sb_mode, sirq_en, f66, mhz}, {25'h7, spf_pkg::FREQ_HIGH_MHZ});
    check("sb_pull", {p3_pu, p4_pu}, 32'h0);
    reg_rd(spf_pkg::STATUS_OFS, rd);
    check("status_sb", rd, 32'h7f);
    @(posedge clk_sys);
    sb_clock_drive_low <= 1'b1;
    sb_data_drive_low <= 1'b1;
    pci_clock_freq_strap <= 1'b0;
    serial_interrupt_line_pullup <= 1'b0;
    pull4 <= 2'h1;
    repeat (2) @(posedge clk_sys);
    #1 check("sb_drive", {p3_oe, p4_oe, sb_data_in, sb_clock_in, p4_out}, 32'h18);
    check("hold", {sb_mode, sirq_en, f66}, 32'h7);
    @(posedge clk_sys);
    sb_clock_drive_low <= 1'b0;
    sb_data_drive_low <= 1'b0;
    $display("Test sb_mode done");
    do_reset();
    check("gpio", {sb_mode, sirq_en}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      {pci_clock_freq_strap, m66en_in} <= i[1:0];
      serial_interrupt_line_pullup <= i[0];
      pcie_reset_n_in <= 1'b0;
      @(posedge clk_sys);
      pcie_reset_n_in <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 check("freq", {f66, mhz}, (i == 3) ? {25'h1, spf_pkg::FREQ_HIGH_MHZ} : {25'h0, spf_pkg::FREQ_LOW_MHZ});
      check("serial_interrupt_line", sirq_en, i[0]);
    end
    $display("Test strap_freq done");
    reg_wr(spf_pkg::CTRL_OFS, 32'ha);
    reg_wr(8'h08, 32'h1f);
    reg_wr(spf_pkg::STATUS_OFS, 32'h7f);
    @(posedge clk_sys);
    #1 check("dir3", {p3_oe, p3_out, p3_pu, p4_oe, p4_pu, sb_mode}, 32'h32);
    reg_rd(spf_pkg::CTRL_OFS, rd);
    check("ctrl", rd, 32'ha);
    reg_rd(8'h08, rd);
    check("unmapped", rd, 32'h0);
    reg_wr(spf_pkg::CTRL_OFS, 32'h14);
    @(posedge clk_sys);
    #1 check("dir4", {p4_oe, p4_out, p4_pu, p3_oe, p3_pu, sb_data_in, sb_clock_in}, 32'h67);
    reg_wr(spf_pkg::CTRL_OFS, 32'h1);
    #1 check("force", {sb_mode, p3_pu, p4_pu}, 32'h4);
    reg_rd(spf_pkg::STATUS_OFS, rd);
    check("status_force", rd[4:0], 32'h1e);
    $display("Test registers done");
    do_reset();
    reg_rd(spf_pkg::CTRL_OFS, rd);
    check("ctrl_rst", rd, 32'h0);
    $display("Test reset done");
    end_of_test();
  end
endmodule
